//--- flow_ctl_params.svh
// Constants for the receive automatic flow controller.
// Assumes a 50 MHz core clock and byte-counted receive FIFO levels.
//
// Behaviour
// - Any-frame qualifier reacts to every frame
// - Full-duplex flow control needs any-frame qualifier
// - Half-duplex any-frame: jam on valid preamble
// - Full-duplex: request pause when threshold reached
// - Pause request held pending until sent, or until transmitter disabled
// - Any-frame qualifier overrides other qualifier bits
// - Duration code maps to speed-dependent jam time
// - High threshold in 64-byte units; one pause
// - Zero-time pause once below low threshold
// - Duration code used only in half-duplex
// - Nothing sent while transmitter is disabled
`ifndef FLOW_CTL_PARAMS_SVH
`define FLOW_CTL_PARAMS_SVH

// =====================================================
// Register map
`define ADDR_W 8
`define CFG_OFS 8'hAC
`define STAT_OFS 8'hC0
`define CFG_RESET 24'h000000
`define CFG_USED_W 24
`define STAT_W 5

// =====================================================
// Threshold units and timing
`define UNIT_SHIFT 6
`define CLK_PERIOD_NS 20
`define NS_PER_US 1000
`define US_CYCLES (`NS_PER_US / `CLK_PERIOD_NS)
`define SLOW_EXTRA_NS 2200
`define JAM_STEP_US 50
`define JAM_LAST_FIXED 4'h3
`define JAM_US_0 5
`define JAM_US_1 10
`define JAM_US_2 15
`define JAM_US_3 25
`define JAM_MAX_NS 602200

`endif

//--- flow_ctl_pkg.sv
// Types shared by the flow controller modules.
// Assumes flow_ctl_params.svh defines the field widths used here.
package flow_ctl_pkg;

  // =====================================================
  // Configuration word, bits 23:0
  typedef struct packed {
    logic [7:0] fifoHighThreshold;
    logic [7:0] fifoLowThreshold;
    logic [3:0] jamDurationCode;
    logic qualifyMulticast;
    logic qualifyBroadcast;
    logic qualifyOwnAddress;
    logic qualifyAnyFrame;
  } cfg_s;

  // Status word, bits 4:0
  typedef struct packed {
    logic pauseSent;
    logic highReached;
    logic backPressure;
    logic pauseZero;
    logic pauseReq;
  } stat_s;

  // Pause request sequencer
  typedef enum logic [3:0] {
    P_IDLE = 4'h1,
    P_PEND_HIGH = 4'h2,
    P_SENT = 4'h4,
    P_PEND_ZERO = 4'h8
  } pause_e;

endpackage : flow_ctl_pkg

//--- jam_timer.sv
// Back-pressure jam timer: decodes the duration code and counts it out.
// Assumes start and abort come from logic on the same clock.
`timescale 1ns/1ns
`include "flow_ctl_params.svh"

module jam_timer #(
  parameter int US_CYC = `US_CYCLES,
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic abort,
  input wire logic [3:0] code,
  input wire logic speed100,
  output logic active
);

  // =====================================================
  // Elaboration check
  if (US_CYC < 1 || 64'(`JAM_MAX_NS) * US_CYC / `NS_PER_US >= (64'd1 << CNT_W))
    $error("jam_timer: counter too narrow for US_CYC");

  // Microseconds for a code at 100 Mb/s
  function automatic int jamMicros(input logic [3:0] c);
    case (c)
      4'h0: return `JAM_US_0;
      4'h1: return `JAM_US_1;
      4'h2: return `JAM_US_2;
      4'h3: return `JAM_US_3;
      default: return (int'(c) - int'(`JAM_LAST_FIXED)) * `JAM_STEP_US;
    endcase
  endfunction : jamMicros

  // =====================================================
  // Decode; 10 Mb/s adds a fixed extra time
  localparam int SLOW_EXTRA = `SLOW_EXTRA_NS * US_CYC / `NS_PER_US;
  wire logic [CNT_W-1:0] loadCycles;
  wire logic [CNT_W-1:0] slowExtra;
  assign slowExtra = speed100 ? '0 : CNT_W'(SLOW_EXTRA);
  assign loadCycles = CNT_W'(jamMicros(code) * US_CYC) + slowExtra;

  logic [CNT_W-1:0] cnt;

  // =====================================================
  // Counter; a new start restarts the jam
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || (ce && abort))
    begin
      cnt <= '0;
      active <= 1'b0;
    end
    else if (ce && start)
    begin
      cnt <= loadCycles - CNT_W'(1);
      active <= 1'b1;
    end
    else if (ce && active)
    begin
      cnt <= cnt - CNT_W'(1);
      active <= (cnt != '0);
    end
  end

  // =====================================================
  // Helper: length of each run against its load
  logic [CNT_W-1:0] runLen;
  logic [CNT_W-1:0] lastLoad;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      runLen <= '0;
      lastLoad <= '0;
    end
    else if (ce)
    begin
      runLen <= start ? CNT_W'(1) : (active ? runLen + CNT_W'(1) : '0);
      lastLoad <= start ? loadCycles : lastLoad;
    end
  end

  jamLength_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && active && cnt == '0 && !start && !abort |-> runLen == lastLoad)
    else $error("jam length differs from decoded time");

  jamRelease_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(active) |-> $past(cnt) == '0 || $past(abort))
    else $error("jam released before count expired");

endmodule : jam_timer

//--- rx_auto_flow_control.sv
// Automatic receive flow controller: pause requests and back pressure.
// Assumes all inputs come from logic on core_clk; MAC acks each pause.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "flow_ctl_params.svh"

module rx_auto_flow_control #(
  parameter int LEVEL_W = 14,
  parameter int US_CYC = `US_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [`ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // Link state
  input wire logic fullDuplex,
  input wire logic speed100,
  input wire logic txEnable,
  // Receive side
  input wire logic [LEVEL_W-1:0] rxFifoLevel,
  input wire logic preambleDetect,
  input wire logic addrDecoded,
  input wire logic frameMulticast,
  input wire logic frameBroadcast,
  input wire logic frameOwnAddr,
  // MAC transmitter
  input wire logic pauseAck,
  output logic pauseReq,
  output logic pauseZero,
  output logic backPressure
);

  // =====================================================
  // Elaboration check
  if (LEVEL_W <= `UNIT_SHIFT || LEVEL_W > 24)
    $error("rx_auto_flow_control: LEVEL_W out of range");

  // FIFO level against a threshold in 64-byte units
  function automatic logic atOrAbove(
    input logic [LEVEL_W-1:0] lvl,
    input logic [7:0] thr
  );
    return 32'(lvl >> `UNIT_SHIFT) >= 32'(thr);
  endfunction : atOrAbove

  // =====================================================
  // Configuration register
  flow_ctl_pkg::cfg_s cfg;

  wire logic cfgHit;
  wire logic statHit;
  assign cfgHit = (regAddr == `CFG_OFS);
  assign statHit = (regAddr == `STAT_OFS);

  // Reserved top byte is not stored
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cfg <= `CFG_RESET;
    else if (ce && regWrite && cfgHit)
      cfg <= regWdata[`CFG_USED_W-1:0];
  end

  // =====================================================
  // Threshold decode
  wire logic highReached;
  wire logic lowFell;
  assign highReached = atOrAbove(rxFifoLevel, cfg.fifoHighThreshold);
  assign lowFell = !atOrAbove(rxFifoLevel, cfg.fifoLowThreshold);

  // Full duplex only with the any-frame bit
  wire logic fdEnable;
  assign fdEnable = fullDuplex && cfg.qualifyAnyFrame && txEnable;

  // =====================================================
  // Half-duplex trigger
  wire logic addrMatch;
  wire logic hdQualified;
  wire logic jamStart;
  wire logic jamAbort;
  assign addrMatch = (cfg.qualifyMulticast && frameMulticast)
                   || (cfg.qualifyBroadcast && frameBroadcast)
                   || (cfg.qualifyOwnAddress && frameOwnAddr);
  // Any-frame skips address decode and masks the other bits
  assign hdQualified = cfg.qualifyAnyFrame
                     ? preambleDetect
                     : (addrDecoded && addrMatch);
  // Duration code is never used in full duplex
  assign jamStart = !fullDuplex && txEnable && highReached && hdQualified;
  assign jamAbort = !txEnable || fullDuplex;

  // Counter loads the code at the current speed
  jam_timer #(
    .US_CYC(US_CYC),
    .CNT_W(16)
  ) jamTimer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(jamStart),
    .abort(jamAbort),
    .code(cfg.jamDurationCode),
    .speed100(speed100),
    .active(backPressure)
  );

  // =====================================================
  // Pause sequencer
  flow_ctl_pkg::pause_e state;
  flow_ctl_pkg::pause_e next_state;

  // One high pause per crossing; zero pause ends it
  always_comb
  begin
    next_state = state;
    case (state)
      flow_ctl_pkg::P_IDLE:
        if (fdEnable && highReached)
          next_state = flow_ctl_pkg::P_PEND_HIGH;
      flow_ctl_pkg::P_PEND_HIGH:
        if (!txEnable)
          next_state = flow_ctl_pkg::P_IDLE;
        else if (pauseAck)
          next_state = flow_ctl_pkg::P_SENT;
      flow_ctl_pkg::P_SENT:
        if (lowFell && txEnable)
          next_state = flow_ctl_pkg::P_PEND_ZERO;
      flow_ctl_pkg::P_PEND_ZERO:
        if (!txEnable)
          next_state = flow_ctl_pkg::P_SENT;
        else if (pauseAck)
          next_state = flow_ctl_pkg::P_IDLE;
      default:
        next_state = flow_ctl_pkg::P_IDLE;
    endcase
  end

  wire logic next_pauseReq;
  wire logic next_pauseZero;
  assign next_pauseReq = (next_state == flow_ctl_pkg::P_PEND_HIGH)
                       || (next_state == flow_ctl_pkg::P_PEND_ZERO);
  assign next_pauseZero = (next_state == flow_ctl_pkg::P_PEND_ZERO);

  // Request is held until the MAC takes it, and withdrawn when txEnable drops
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= flow_ctl_pkg::P_IDLE;
      pauseReq <= 1'b0;
      pauseZero <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      pauseReq <= next_pauseReq;
      pauseZero <= next_pauseZero;
    end
  end

  // =====================================================
  // Status and read data
  flow_ctl_pkg::stat_s stat;
  assign stat.pauseSent = (state == flow_ctl_pkg::P_SENT)
                        || (state == flow_ctl_pkg::P_PEND_ZERO);
  assign stat.highReached = highReached;
  assign stat.backPressure = backPressure;
  assign stat.pauseZero = pauseZero;
  assign stat.pauseReq = pauseReq;

  wire logic [31:0] readMux;
  assign readMux = cfgHit ? {8'h00, cfg}
                 : (statHit ? {27'h0000000, stat} : 32'h00000000);

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      regRdata <= 32'h00000000;
    else if (ce)
      regRdata <= regRead ? readMux : 32'h00000000;
  end

  // =====================================================
  // Checks
  fdPauseStart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && state == flow_ctl_pkg::P_IDLE && fdEnable && highReached
    |=> pauseReq && !pauseZero)
    else $error("pause not requested at threshold");

  fdGate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pauseReq) && !pauseZero |-> $past(fullDuplex && cfg.qualifyAnyFrame))
    else $error("pause requested without full-duplex enable");

  txOffQuiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && !txEnable |=> !backPressure && (!pauseReq || $past(pauseReq)))
    else $error("activity while transmitter disabled");

  reqHeld_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pauseReq && !pauseAck && txEnable |=> pauseReq && $stable(pauseZero))
    else $error("pending pause dropped");

  onePause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == flow_ctl_pkg::P_SENT && !lowFell |=> !pauseReq)
    else $error("second pause in one crossing");

  zeroPause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && state == flow_ctl_pkg::P_SENT && lowFell && txEnable
    |=> pauseReq && pauseZero)
    else $error("zero pause not requested below low level");

  preambleJam_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && !fullDuplex && txEnable && highReached && cfg.qualifyAnyFrame
    && preambleDetect |=> backPressure)
    else $error("no jam on preamble");

  anyOverride_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && cfg.qualifyAnyFrame && !preambleDetect && !backPressure
    |=> !backPressure)
    else $error("jam without preamble in any-frame mode");

  fdNoJam_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && fullDuplex |=> !backPressure)
    else $error("jam in full duplex");

  addrJam_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce && !cfg.qualifyAnyFrame && !fullDuplex && txEnable && highReached
    && addrDecoded && cfg.qualifyOwnAddress && frameOwnAddr |=> backPressure)
    else $error("no jam on own-address frame");

endmodule : rx_auto_flow_control

//--- mac_tx_model.sv
// MAC transmitter stand-in that answers pause requests with an acknowledge.
// Assumes the bench drives txBusy and ackDelay from core_clk edges.
`timescale 1ns/1ns

module mac_tx_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pauseReq,
  input wire logic txBusy,
  input wire logic [3:0] ackDelay,
  output logic pauseAck
);
  logic [3:0] waitCnt;

  // ==========================================================
  // Pause goes out on the idle cycle after ackDelay counted idle cycles, and never cuts a frame short
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !pauseReq || pauseAck)
    begin
      waitCnt <= 4'h0;
      pauseAck <= 1'b0;
    end
    else if (!txBusy && waitCnt >= ackDelay)
      pauseAck <= 1'b1;
    else if (!txBusy)
      waitCnt <= waitCnt + 4'h1;
  end
endmodule : mac_tx_model

//--- test_rx_auto_flow_control.sv
// Self-checking bench for the receive automatic flow controller.
// Assumes the jam timer runs with one cycle per microsecond.
`timescale 1ns/1ns
`include "flow_ctl_params.svh"

module test_rx_auto_flow_control;
  localparam int US = 1;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata;
  logic fullDuplex = 1'b1;
  logic speed100 = 1'b1;
  logic txEnable = 1'b1;
  logic [13:0] rxFifoLevel = 14'h0;
  logic preambleDetect = 1'b0;
  logic addrDecoded = 1'b0;
  logic [2:0] frameClass = 3'h0;
  logic txBusy = 1'b0;
  logic [3:0] ackDelay = 4'h2;
  logic pauseAck, pauseReq, pauseZero, backPressure;
  logic [31:0] rd;
  int errors = 0;
  int checked = 0;
  int n;

  always #10 core_clk = ~core_clk;

  // Clock enable stays high except in the freeze scenario
  rx_auto_flow_control #(.LEVEL_W(14), .US_CYC(US)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .fullDuplex(fullDuplex), .speed100(speed100), .txEnable(txEnable),
    .rxFifoLevel(rxFifoLevel), .preambleDetect(preambleDetect), .addrDecoded(addrDecoded),
    .frameMulticast(frameClass[2]), .frameBroadcast(frameClass[1]),
    .frameOwnAddr(frameClass[0]), .pauseAck(pauseAck), .pauseReq(pauseReq),
    .pauseZero(pauseZero), .backPressure(backPressure));

  mac_tx_model i_mac (.core_clk(core_clk), .rst_n(rst_n), .pauseReq(pauseReq),
    .txBusy(txBusy), .ackDelay(ackDelay), .pauseAck(pauseAck));

  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : reg_read

  task automatic cfg(input logic [7:0] hi, input logic [3:0] code, input logic [3:0] qual);
    reg_write(`CFG_OFS, {8'h00, hi, 8'h01, code, qual});
  endtask : cfg

  // One frame start, then count the cycles of jam that follow
  task automatic frame(input logic pre, input logic [2:0] cls, output int cnt);
    @(posedge core_clk);
    preambleDetect <= pre;
    addrDecoded <= !pre;
    frameClass <= cls;
    @(posedge core_clk);
    preambleDetect <= 1'b0;
    addrDecoded <= 1'b0;
    frameClass <= 3'h0;
    #1 cnt = 0;
    while (backPressure === 1'b1 && cnt < 1000)
    begin
      cnt++;
      @(posedge core_clk);
      #1;
    end
  endtask : frame

  task automatic wait_release();
    int k;
    k = 0;
    while (pauseReq === 1'b1 && k < 50)
    begin
      k++;
      @(posedge core_clk);
      #1;
    end
    chk("pauseReq released", 32'h0, {31'h0, pauseReq});
  endtask : wait_release

  function automatic int jam_len(input logic [3:0] code, input logic fast);
    int us;
    us = (code == 4'h0) ? 5 : (code == 4'h1) ? 10 : (code == 4'h2) ? 15 :
      (code == 4'h3) ? 25 : (code - 3) * 50;
    return us * US + (fast ? 0 : (2200 * US) / 1000);
  endfunction : jam_len

  // ==========================================================
  // Scenarios
  task automatic test_registers();
    reg_read(`CFG_OFS, rd);
    chk("config reset", 32'h0, rd);
    reg_write(`CFG_OFS, 32'hFFFFFFFF);
    reg_read(`CFG_OFS, rd);
    chk("config reserved", 32'h00FFFFFF, rd);
    reg_write(8'h10, 32'hFFFFFFFF);
    reg_read(8'h10, rd);
    chk("unmapped read", 32'h0, rd);
    reg_write(`STAT_OFS, 32'hFFFFFFFF);
    reg_read(`STAT_OFS, rd);
    chk("status read-only", 32'h0, rd);
  endtask : test_registers

  // Full duplex: one pause at the high mark, a zero pause below the low mark
  task automatic test_pause();
    cfg(8'h02, 4'h0, 4'h1);
    txBusy <= 1'b1;
    rxFifoLevel <= 14'd128;
    @(posedge core_clk);
    @(posedge core_clk);
    #1 chk("pause request", 32'h1, {pauseZero, pauseReq});
    repeat (8) @(posedge core_clk);
    #1 chk("pause pending", 32'h1, {31'h0, pauseReq});
    reg_read(`STAT_OFS, rd);
    chk("status pending", 32'h9, rd);
    @(posedge core_clk);
    txBusy <= 1'b0;
    wait_release();
    repeat (10) @(posedge core_clk);
    #1 chk("single pause", 32'h0, {31'h0, pauseReq});
    @(posedge core_clk);
    rxFifoLevel <= 14'd64;
    repeat (6) @(posedge core_clk);
    #1 chk("at low mark", 32'h0, {31'h0, pauseReq});
    @(posedge core_clk);
    rxFifoLevel <= 14'd63;
    @(posedge core_clk);
    @(posedge core_clk);
    #1 chk("zero pause", 32'h3, {pauseZero, pauseReq});
    wait_release();
  endtask : test_pause

  // Without the any-frame bit full duplex stays quiet, and no jam there
  task automatic test_full_off();
    cfg(8'h02, 4'h0, 4'hE);
    rxFifoLevel <= 14'd128;
    frame(1'b0, 3'h7, n);
    chk("fd no jam", 32'h0, n);
    chk("fd no pause", 32'h0, {31'h0, pauseReq});
    @(posedge core_clk);
    txEnable <= 1'b0;
    cfg(8'h02, 4'h0, 4'h1);
    repeat (5) @(posedge core_clk);
    #1 chk("tx off pause", 32'h0, {31'h0, pauseReq});
    @(posedge core_clk);
    fullDuplex <= 1'b0;
    frame(1'b1, 3'h0, n);
    chk("tx off jam", 32'h0, n);
    @(posedge core_clk);
    txEnable <= 1'b1;
  endtask : test_full_off

  // Half duplex: every duration code at 100 Mb/s, the shortest and longest codes at 10 Mb/s
  task automatic test_jam();
    for (int c = 0; c < 16; c++)
    begin
      cfg(8'h02, c[3:0], 4'h1);
      frame(1'b1, 3'h0, n);
      chk("jam length", jam_len(c[3:0], 1'b1), n);
    end
    @(posedge core_clk);
    speed100 <= 1'b0;
    cfg(8'h02, 4'h0, 4'h1);
    frame(1'b1, 3'h0, n);
    chk("slow jam short", jam_len(4'h0, 1'b0), n);
    cfg(8'h02, 4'hF, 4'h1);
    frame(1'b1, 3'h0, n);
    chk("slow jam long", jam_len(4'hF, 1'b0), n);
    @(posedge core_clk);
    speed100 <= 1'b1;
    rxFifoLevel <= 14'd127;
    frame(1'b1, 3'h0, n);
    chk("below threshold", 32'h0, n);
    @(posedge core_clk);
    rxFifoLevel <= 14'd128;
  endtask : test_jam

  task automatic test_qualify();
    cfg(8'h02, 4'h0, 4'h8);
    frame(1'b0, 3'h4, n);
    chk("multicast jam", 32'd5, n);
    frame(1'b0, 3'h2, n);
    chk("broadcast off", 32'h0, n);
    cfg(8'h02, 4'h0, 4'h4);
    frame(1'b0, 3'h2, n);
    chk("broadcast jam", 32'd5, n);
    cfg(8'h02, 4'h0, 4'h8);
    frame(1'b1, 3'h0, n);
    chk("preamble unqualified", 32'h0, n);
    cfg(8'h02, 4'h0, 4'h2);
    frame(1'b0, 3'h1, n);
    chk("own address jam", 32'd5, n);
    cfg(8'h02, 4'h0, 4'hF);
    frame(1'b1, 3'h0, n);
    chk("any overrides", 32'd5, n);
    frame(1'b0, 3'h7, n);
    chk("any skips address", 32'h0, n);
  endtask : test_qualify

  // Clock enable low holds the jam counter where it stands
  task automatic test_freeze();
    cfg(8'h02, 4'h0, 4'h1);
    @(posedge core_clk);
    preambleDetect <= 1'b1;
    @(posedge core_clk);
    preambleDetect <= 1'b0;
    ce <= 1'b0;
    repeat (10) @(posedge core_clk);
    ce <= 1'b1;
    #1 chk("frozen jam", 32'h1, {31'h0, backPressure});
    n = 0;
    while (backPressure === 1'b1 && n < 50)
    begin
      n++;
      @(posedge core_clk);
      #1;
    end
    chk("resumed jam", jam_len(4'h0, 1'b1), n);
  endtask : test_freeze

  // Reset in mid-jam clears outputs and configuration
  task automatic test_reset();
    @(posedge core_clk);
    preambleDetect <= 1'b1;
    @(posedge core_clk);
    preambleDetect <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk("reset outputs", 32'h0, {29'h0, pauseReq, pauseZero, backPressure});
    reg_read(`CFG_OFS, rd);
    chk("reset config", 32'h0, rd);
  endtask : test_reset

  task automatic give_verdict();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    test_registers();
    test_pause();
    test_full_off();
    test_jam();
    test_qualify();
    test_freeze();
    test_reset();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    give_verdict();
  end
endmodule : test_rx_auto_flow_control
